//--- rtl/digital_line_group_io.sv
/*
  Digital line group input/output unit with an AHB-Lite register slave.
  Assumes a single master, word transfers only, inputs synchronous to hclk.
*/
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module digital_line_group_io #(
  parameter int INTERLOCK_CYCLES = dlg_pkg::INTERLOCK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic reader_contact,
  input wire logic [dlg_pkg::READER_LINES-1:0] reader_lines,
  input wire logic tape_position_ready_n,
  input wire logic [dlg_pkg::GROUPS-1:0][dlg_pkg::LINES-1:0] group_input_line,
  output logic reader_group_select,
  output logic tape_advance_request,
  output logic [dlg_pkg::LINES-1:0] output_buffer,
  output logic one_bit_level,
  output logic [dlg_pkg::GROUPS-1:0][dlg_pkg::LINES-1:0] relay_state
);
  dlg_pkg::state_t state_r;
  dlg_pkg::state_t state_nxt;
  dlg_pkg::cmd_t cmd_r;
  logic [4:0] dt_r;
  logic [17:0] acc_r;
  logic [4:0] line_countdown_r;
  logic [4:0] held_group_address_r;
  logic equality_flag_r;
  logic reader_group_select_r;
  logic tape_advance_request_r;
  logic level_r;
  logic [17:0] output_buffer_r;
  logic [31:0][17:0] relay_r;
  logic [2:0] settle_r;
  logic primary_reader_ready_r;
  logic [31:0] interlock_r;
  logic ap_valid_r;
  logic ap_write_r;
  logic [7:0] ap_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  wire direction_bit = cmd_r.addr[5];
  wire is_primary = cmd_r.addr == dlg_pkg::GRP_PRIMARY;
  wire is_secondary = cmd_r.addr == dlg_pkg::GRP_SECONDARY;
  wire tape_ready = ~tape_position_ready_n;
  wire interlock_busy = interlock_r != 32'h0000_0000;
  wire dt_last = dt_r == dlg_pkg::DT_LAST;
  wire dt_data = dt_r <= dlg_pkg::DT_DATA_END;
  wire [4:0] dt_idx = dt_r - dlg_pkg::DT_FIRST;

  // readiness per direction and group
  wire ready_in = is_primary ? (primary_reader_ready_r & ~interlock_busy)
    : is_secondary ? tape_ready
    : 1'b1;
  wire ready_w = direction_bit ? ready_in : 1'b1;

  // line selection and serial gating
  wire [17:0] reader_vec = {reader_lines, 11'h000};
  wire [17:0] group_vec = group_input_line[held_group_address_r];
  wire [17:0] src_vec = reader_group_select_r ? reader_vec : group_vec;
  wire [4:0] line_idx = dlg_pkg::CNT_FULL - line_countdown_r;
  wire cnt_in_range = line_countdown_r != 5'h00 && line_countdown_r <= dlg_pkg::CNT_FULL;
  // counts past 19 are not modelled bit-exact; they sample nothing
  wire serial_bit = line_countdown_r == dlg_pkg::CNT_OR ? (src_vec[0] | src_vec[1])
    : cnt_in_range ? src_vec[line_idx]
    : 1'b0;
  wire sample_bit = equality_flag_r ? 1'b0 : serial_bit;
  wire out_apply = state_r == dlg_pkg::ST_XFER && dt_last && !direction_bit;

  // bus decode
  wire ahb_take = hsel && htrans[1] && hready;
  wire wr_cmd = ap_valid_r && ap_write_r && ap_addr_r == dlg_pkg::OFS_CMD;
  wire wr_acc = ap_valid_r && ap_write_r && ap_addr_r == dlg_pkg::OFS_ACC;
  wire idle = state_r == dlg_pkg::ST_IDLE;
  wire [31:0] stat_word = {12'h000, state_r, equality_flag_r, reader_group_select_r,
    tape_advance_request_r, interlock_busy, 2'b00, line_countdown_r, held_group_address_r};
  logic [31:0] rdata_w;
  always_comb begin
    if (haddr[7:0] == dlg_pkg::OFS_CMD) begin
      rdata_w = {20'h0_0000, cmd_r};
    end else if (haddr[7:0] == dlg_pkg::OFS_ACC) begin
      rdata_w = {14'h0000, acc_r};
    end else if (haddr[7:0] == dlg_pkg::OFS_STAT) begin
      rdata_w = stat_word;
    end else if (haddr[7:0] == dlg_pkg::OFS_OUT) begin
      rdata_w = {14'h0000, output_buffer_r};
    end else begin
      rdata_w = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      ap_valid_r <= ahb_take;
      ap_write_r <= hwrite;
      ap_addr_r <= haddr[7:0];
      hrdata_r <= (ahb_take && !hwrite) ? rdata_w : 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  // machine states
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dlg_pkg::ST_IDLE: begin
        if (wr_cmd) begin
          state_nxt = dlg_pkg::ST_WAIT;
        end
      end
      dlg_pkg::ST_WAIT: begin
        if (dt_last && equality_flag_r) begin
          state_nxt = dlg_pkg::ST_XFER;
        end
      end
      dlg_pkg::ST_XFER: begin
        if (dt_last) begin
          state_nxt = direction_bit ? dlg_pkg::ST_SAMPLE : dlg_pkg::ST_IDLE;
        end
      end
      dlg_pkg::ST_SAMPLE: begin
        if (dt_last) begin
          state_nxt = dlg_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = dlg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= dlg_pkg::ST_IDLE;
      dt_r <= dlg_pkg::DT_FIRST;
      cmd_r <= '0;
    end else begin
      state_r <= state_nxt;
      dt_r <= dt_last ? dlg_pkg::DT_FIRST : dt_r + 5'h01;
      if (wr_cmd && idle) begin
        cmd_r <= hwdata[11:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      equality_flag_r <= 1'b0;
    end else if (state_r == dlg_pkg::ST_WAIT) begin
      equality_flag_r <= equality_flag_r | ready_w;
    end else if (state_r == dlg_pkg::ST_SAMPLE) begin
      equality_flag_r <= equality_flag_r | (line_countdown_r == 5'h00);
    end else begin
      equality_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reader_group_select_r <= 1'b0;
    end else if (state_r == dlg_pkg::ST_WAIT && is_primary) begin
      reader_group_select_r <= 1'b1;
    end else if (state_r == dlg_pkg::ST_SAMPLE && dt_last) begin
      reader_group_select_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tape_advance_request_r <= 1'b0;
    end else if (dt_last) begin
      tape_advance_request_r <= 1'b0;
    end else if (state_r == dlg_pkg::ST_XFER && is_secondary) begin
      tape_advance_request_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_group_address_r <= 5'h00;
    end else if (state_r == dlg_pkg::ST_WAIT && dt_last && equality_flag_r) begin
      held_group_address_r <= cmd_r.addr[4:0];
    end
  end

  // execution time enters msb first over digits 1..5
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_countdown_r <= 5'h00;
    end else if (state_r == dlg_pkg::ST_XFER && dt_r <= dlg_pkg::DT_EXEC_END) begin
      line_countdown_r <= {line_countdown_r[3:0], cmd_r.exec[3'(dlg_pkg::DT_EXEC_END - dt_r)]};
    end else if (state_r == dlg_pkg::ST_SAMPLE && dt_r != dlg_pkg::DT_SKIP
        && line_countdown_r != 5'h00) begin
      line_countdown_r <= line_countdown_r - 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 18'h0_0000;
    end else if (wr_acc && idle) begin
      acc_r <= hwdata[17:0];
    end else if (state_r == dlg_pkg::ST_SAMPLE && dt_data) begin
      acc_r[dt_idx] <= sample_bit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_buffer_r <= 18'h0_0000;
      level_r <= 1'b0;
    end else if (state_r == dlg_pkg::ST_XFER && !direction_bit && dt_data) begin
      output_buffer_r[dt_idx] <= acc_r[dt_idx];
      if (dt_r == dlg_pkg::DT_FIRST) begin
        level_r <= cmd_r.exec[0];
      end
    end
  end

  // latching relays, one group per generate pass
  for (genvar g = 0; g < dlg_pkg::GROUPS; g++) begin : g_relay
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        relay_r[g] <= 18'h0_0000;
      end else if (out_apply && held_group_address_r == 5'(g)) begin
        if (!cmd_r.one_bit) begin
          relay_r[g] <= output_buffer_r;
        end else if (level_r) begin
          relay_r[g] <= relay_r[g] | output_buffer_r;
        end else begin
          relay_r[g] <= relay_r[g] & ~output_buffer_r;
        end
      end
    end
  end

  // contact must stay closed through the whole chain, one pulse per closure
  // chain held clear while the print interlock runs, else the single pulse is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_r <= 3'h0;
      primary_reader_ready_r <= 1'b0;
    end else begin
      if (!reader_contact || interlock_busy) begin
        settle_r <= 3'h0;
      end else if (settle_r != 3'(dlg_pkg::SETTLE_CYC)) begin
        settle_r <= settle_r + 3'h1;
      end
      primary_reader_ready_r <= reader_contact && settle_r == 3'(dlg_pkg::SETTLE_CYC - 1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interlock_r <= 32'h0000_0000;
    end else if (out_apply && held_group_address_r == dlg_pkg::GRP_PRINTER) begin
      interlock_r <= 32'(INTERLOCK_CYCLES);
    end else if (interlock_busy) begin
      interlock_r <= interlock_r - 32'h0000_0001;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign reader_group_select = reader_group_select_r;
  assign tape_advance_request = tape_advance_request_r;
  assign output_buffer = output_buffer_r;
  assign one_bit_level = level_r;
  assign relay_state = relay_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_primary_hold;
    state_r == dlg_pkg::ST_WAIT && is_primary && !equality_flag_r && !primary_reader_ready_r
      |=> state_r == dlg_pkg::ST_WAIT;
  endproperty
  a_primary_hold: assert property (p_primary_hold) else $error("left wait without ready");
  property p_select_set;
    state_r == dlg_pkg::ST_WAIT && is_primary |=> reader_group_select_r;
  endproperty
  a_select_set: assert property (p_select_set) else $error("select flag not set");
  property p_select_clear;
    state_r == dlg_pkg::ST_SAMPLE && dt_last |=> !reader_group_select_r && state_r == dlg_pkg::ST_IDLE;
  endproperty
  a_select_clear: assert property (p_select_clear) else $error("select flag not cleared");
  property p_advance_clear;
    tape_advance_request_r && dt_last |=> !tape_advance_request_r;
  endproperty
  a_advance_clear: assert property (p_advance_clear) else $error("advance not cleared");
  property p_hold_addr;
    state_r == dlg_pkg::ST_WAIT && dt_last && equality_flag_r |=> held_group_address_r == $past(cmd_r.addr[4:0]);
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("group address not held");
  property p_count_load;
    state_r == dlg_pkg::ST_XFER && dt_r == dlg_pkg::DT_EXEC_END |=> line_countdown_r == cmd_r.exec;
  endproperty
  a_count_load: assert property (p_count_load) else $error("counter not loaded");
  property p_count_step;
    state_r == dlg_pkg::ST_SAMPLE && line_countdown_r != 5'h00 && dt_r != dlg_pkg::DT_SKIP
      |=> line_countdown_r == $past(line_countdown_r) - 5'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");
  property p_interlock;
    state_r == dlg_pkg::ST_WAIT && is_primary && interlock_busy && !equality_flag_r
      |=> state_r == dlg_pkg::ST_WAIT && !equality_flag_r;
  endproperty
  a_interlock: assert property (p_interlock) else $error("interlock ignored");
endmodule

//--- rtl/dlg_pkg.sv
/*
  Constants, command layout and state codes for the digital line group unit.
  Assumes a 100 MHz hclk where one clock is one digit time.
*/
package dlg_pkg;
  localparam int CLK_MHZ = 100;
  localparam int INTERLOCK_MS = 110;
  localparam int INTERLOCK_CYC = INTERLOCK_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYC = 4;
  localparam int LINES = 18;
  localparam int GROUPS = 32;
  localparam int READER_LINES = 7;
  localparam int READER_BASE = 11;
  localparam logic [4:0] DT_FIRST = 5'h01;
  localparam logic [4:0] DT_EXEC_END = 5'h05;
  localparam logic [4:0] DT_DATA_END = 5'h12;
  localparam logic [4:0] DT_SKIP = 5'h13;
  localparam logic [4:0] DT_LAST = 5'h14;
  localparam logic [4:0] CNT_FULL = 5'h12;
  localparam logic [4:0] CNT_OR = 5'h13;
  localparam logic [5:0] GRP_PRIMARY = 6'h20;
  localparam logic [5:0] GRP_SECONDARY = 6'h21;
  localparam logic [4:0] GRP_PRINTER = 5'h00;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_OUT = 8'h0C;

  typedef struct packed {
    logic one_bit;
    logic [4:0] exec;
    logic [5:0] addr;
  } cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_XFER = 4'h4,
    ST_SAMPLE = 4'h8
  } state_t;
endpackage

//--- verification/tape_reader_model.sv
/*
  Behavioural model of the two punched-tape readers facing the line group unit.
  Assumes the bench supplies the character under the primary feelers and whether tape is loaded.
*/
`timescale 1ns/1ps
module tape_reader_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reader_group_select,
  input wire logic tape_advance_request,
  input wire logic [6:0] char_data,
  input wire logic [7:0] contact_delay,
  input wire logic tape_loaded,
  output logic reader_contact,
  output logic [6:0] reader_lines,
  output logic tape_position_ready_n
);
  int pwr_cnt;
  int move_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_cnt <= 0;
      move_cnt <= 0;
    end else begin
      pwr_cnt <= reader_group_select ? pwr_cnt + 1 : 0;
      if (tape_advance_request) begin
        move_cnt <= 6;
      end else if (move_cnt != 0) begin
        move_cnt <= move_cnt - 1;
      end
    end
  end
  // feelers close only once the reader is powered, after a settable travel time
  assign reader_contact = pwr_cnt > int'(contact_delay);
  // unpowered input relays drop out, so lines no longer show the character
  assign reader_lines = reader_group_select ? char_data : ~char_data;
  assign tape_position_ready_n = !(tape_loaded && move_cnt == 0);
endmodule

//--- verification/tb_digital_line_group_io.sv
/*
  Self-checking bench for digital_line_group_io: random and corner commands over AHB-Lite.
  Assumes tape_reader_model on the reader pins and a zero-wait slave.
*/
`timescale 1ns/1ps
module tb_digital_line_group_io;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tape_loaded = 1;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [6:0] char_data = 0, reader_lines;
  logic [7:0] contact_delay = 8'h02;
  logic [31:0][17:0] lines_in = '0, relay_state;
  logic [17:0] exp_rel [32];
  logic [17:0] output_buffer;
  logic [31:0] hrdata;
  logic hreadyout, hresp, reader_contact, tape_position_ready_n, reader_group_select, tape_advance_request;
  logic one_bit_level;
  logic [5:0] a;
  logic [4:0] e;
  int fail_count = 0, check_count = 0, adv_cnt = 0, sel_cnt = 0, a0, s0;
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    adv_cnt <= adv_cnt + int'(tape_advance_request);
    sel_cnt <= sel_cnt + int'(reader_group_select);
  end
  digital_line_group_io #(.INTERLOCK_CYCLES(200)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reader_contact(reader_contact),
    .reader_lines(reader_lines), .tape_position_ready_n(tape_position_ready_n), .group_input_line(lines_in),
    .reader_group_select(reader_group_select), .tape_advance_request(tape_advance_request),
    .output_buffer(output_buffer), .one_bit_level(one_bit_level), .relay_state(relay_state));
  tape_reader_model readers (.hclk(hclk), .hresetn(hresetn), .reader_group_select(reader_group_select),
    .tape_advance_request(tape_advance_request), .char_data(char_data), .contact_delay(contact_delay),
    .tape_loaded(tape_loaded), .reader_contact(reader_contact), .reader_lines(reader_lines),
    .tape_position_ready_n(tape_position_ready_n));

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] addr, logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 400; i++) begin
      bus(1'b0, dlg_pkg::OFS_STAT, 32'h0);
      if (rd[19:16] == 4'h1) return;
    end
    chk("return to idle", 32'h1, 32'h0);
  endtask
  task automatic cmd(logic [5:0] ad, logic [4:0] ex, logic ob);
    bus(1'b1, dlg_pkg::OFS_CMD, {20'h0, ob, ex, ad});
  endtask
  task automatic chk_acc(logic [17:0] x);
    bus(1'b0, dlg_pkg::OFS_ACC, 32'h0);
    chk("accumulator", {14'h0, x}, rd);
  endtask
  task automatic chk_relays;
    for (int g = 0; g < 32; g++) chk("relay group", {14'h0, exp_rel[g]}, {14'h0, relay_state[g]});
  endtask
  task automatic out_cmd(logic [5:0] ad, logic [4:0] ex, logic ob, logic [17:0] p);
    bus(1'b1, dlg_pkg::OFS_ACC, {14'h0, p});
    cmd(ad, ex, ob);
    wait_idle();
    exp_rel[ad[4:0]] = ob ? (ex[0] ? exp_rel[ad[4:0]] | p : exp_rel[ad[4:0]] & ~p) : p;
    chk("output buffer", {14'h0, p}, {14'h0, output_buffer});
    if (ob) chk("one bit level", {31'h0, ex[0]}, {31'h0, one_bit_level});
    chk_relays();
  endtask
  function automatic logic [17:0] exp_in(logic [17:0] g, int x);
    logic [17:0] r = '0;
    for (int k = 0; k < 18; k++) if (18 - x + k >= 0 && 18 - x + k < 18) r[k] = g[18 - x + k];
    if (x == 19) r[0] = g[0] | g[1];
    return r;
  endfunction

  initial begin
    #800_000;
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'h4b4f));
    foreach (exp_rel[g]) exp_rel[g] = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, dlg_pkg::OFS_STAT, 32'h0);
    chk("status after reset", 32'h0001_0000, rd);
    chk("response", 32'h0, {31'h0, hresp});
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, rd);
    $display("reset test done");
    for (int n = 0; n < 12; n++) begin
      a = 6'h24 + 6'($urandom_range(27));
      e = (n < 3) ? 5'h11 + 5'(n) : 5'($urandom_range(1, 19));
      for (int g = 0; g < 32; g++) lines_in[g] <= 18'($urandom);
      cmd(a, e, 1'b0);
      wait_idle();
      chk_acc(exp_in(lines_in[a[4:0]], int'(e)));
    end
    $display("input group test done");
    out_cmd(6'h00, 5'h01, 1'b0, 18'h0_00ff);
    char_data <= 7'($urandom);
    s0 = sel_cnt;
    cmd(6'h20, 5'h12, 1'b0);
    repeat (60) @(posedge hclk);
    bus(1'b0, dlg_pkg::OFS_STAT, 32'h0);
    chk("interlock hold", 32'h0000_0005, 32'({rd[19:16], rd[12]}));
    wait_idle();
    chk_acc(exp_in({char_data, 11'h0}, 18));
    contact_delay <= 8'h1e;
    char_data <= 7'($urandom);
    cmd(6'h20, 5'h11, 1'b0);
    repeat (20) @(posedge hclk);
    bus(1'b0, dlg_pkg::OFS_STAT, 32'h0);
    chk("wait for reader ready", 32'h2, 32'(rd[19:16]));
    wait_idle();
    chk_acc(exp_in({char_data, 11'h0}, 17));
    chk("select seen", 32'h1, 32'(sel_cnt > s0));
    chk("select cleared", 32'h0, {31'h0, reader_group_select});
    $display("primary reader test done");
    tape_loaded <= 1'b0;
    lines_in[1] <= 18'($urandom);
    a0 = adv_cnt;
    s0 = sel_cnt;
    cmd(6'h21, 5'h12, 1'b0);
    repeat (45) @(posedge hclk);
    bus(1'b0, dlg_pkg::OFS_STAT, 32'h0);
    chk("wait for tape", 32'h2, 32'(rd[19:16]));
    tape_loaded <= 1'b1;
    wait_idle();
    chk_acc(exp_in(lines_in[1], 18));
    chk("advance cycles", 32'(19), 32'(adv_cnt - a0));
    chk("select in secondary", 32'h0, 32'(sel_cnt - s0));
    $display("secondary reader test done");
    for (int n = 0; n < 10; n++) out_cmd(6'($urandom_range(1, 31)), 5'($urandom_range(1, 19)), 1'($urandom),
      18'($urandom));
    out_cmd(6'h1f, 5'h03, 1'b1, 18'h2_0001);
    out_cmd(6'h1f, 5'h02, 1'b1, 18'h0_0001);
    bus(1'b1, dlg_pkg::OFS_ACC, 32'h0001_2345);
    cmd(6'h09, 5'h01, 1'b0);
    bus(1'b1, dlg_pkg::OFS_ACC, 32'h0000_0f0f);
    cmd(6'h0a, 5'h01, 1'b0);
    wait_idle();
    exp_rel[9] = 18'h1_2345;
    chk_relays();
    $display("output test done");
    final_report();
  end
endmodule
